// >>> rtl/gpx_gpio.sv
// bank of eight gpio ports with masked data access, pin interrupts and pad control
module gpx_gpio #(
  parameter logic [63:0] PAD_MASK = '1,
  parameter logic [31:0] UNLOCK_KEY = 32'h1234_5678, // arbitrary value
  parameter logic [63:0] PERIPH_ID = 64'h0706_0504_0302_0100, // arbitrary value
  parameter logic [31:0] CELL_ID = 32'h0B0A_0908 // arbitrary value
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register access
  input gpx_pkg::gpx_req_s req,
  output logic [31:0] rdata,
  output logic rd_valid,
  // pads
  input wire logic [63:0] pin_in,
  output logic [63:0] pin_out,
  output logic [63:0] pin_oe,
  output gpx_pkg::gpx_pad_s [7:0] pad_cfg,
  // peripherals on alternate function
  input wire logic [63:0] alt_out,
  input wire logic [63:0] alt_oe,
  output logic [63:0] alt_in,
  // one interrupt per port
  output logic [7:0] irq
);
  import gpx_pkg::*;

  localparam gpx_top_s RST_ST = gpx_rst_top();

  gpx_top_s st_ff;
  gpx_top_s nxt_st;
  logic [GPX_PINS-1:0] pin_sync;

  // one synchroniser per port; pad config leaves straight from its flops
  for (genvar g = 0; g < GPX_PORTS; g++) begin : g_port
    gpx_sync u_sync (
      .mclk(mclk),
      .rst(rst),
      .d(pin_in[g*GPX_W +: GPX_W]),
      .q(pin_sync[g*GPX_W +: GPX_W])
    );
    assign pad_cfg[g] = st_ff.prt[g].pad;
  end

  // next state of all eight ports
  always_comb begin
    gpx_port_s pr;
    gpx_port_s pn;
    logic [7:0] cm;
    logic [7:0] dbg;
    logic [7:0] inv;
    logic [7:0] wd;
    logic [7:0] clr;
    logic [7:0] allow;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] edg;
    logic [7:0] lvl;
    logic [7:0] ov;
    logic [7:0] ev;
    logic [31:0] rv;
    logic [11:0] a;
    logic [3:0] idx;
    logic sel;
    pr = '0;
    pn = '0;
    cm = '0;
    dbg = '0;
    inv = '0;
    clr = '0;
    allow = '0;
    rise = '0;
    fall = '0;
    edg = '0;
    lvl = '0;
    ov = '0;
    ev = '0;
    rv = '0;
    sel = 1'b0;
    a = req.addr;
    idx = req.addr[5:2];
    wd = req.wdata[7:0];
    nxt_st = st_ff;
    nxt_st.rd_valid = 1'b0;
    for (int p = 0; p < GPX_PORTS; p++) begin
      pr = st_ff.prt[p];
      pn = pr;
      cm = PAD_MASK[p*GPX_W +: GPX_W];
      dbg = DBG_PINS[p*GPX_W +: GPX_W];
      sel = (req.port == 3'(p));
      clr = '0;
      allow = '0;
      // a disabled input reads low, like a pad with no digital buffer
      inv = pin_sync[p*GPX_W +: GPX_W] & pr.pad.digital_input_enable;

      // register writes; pad-less bits are never touched
      if (req.wr && sel) begin
        if (a[11:10] == 2'b00) begin
          pn.pin_value_reg = gpx_upd(pr.pin_value_reg, wd, a[9:2] & cm);
        end else begin
          case (a)
            OFS_DIR: pn.pin_direction_select = gpx_upd(pr.pin_direction_select, wd, cm);
            OFS_IS: pn.irq_sense_select = gpx_upd(pr.irq_sense_select, wd, cm);
            OFS_IBE: pn.irq_both_edges_select = gpx_upd(pr.irq_both_edges_select, wd, cm);
            OFS_IEV: pn.irq_event_polarity = gpx_upd(pr.irq_event_polarity, wd, cm);
            OFS_IM: pn.irq_mask = gpx_upd(pr.irq_mask, wd, cm);
            OFS_ICR: clr = wd & cm;
            OFS_AFSEL: begin
              // protected bits need the unlock key and their commit bit
              allow = cm & (~dbg | ({8{~pr.commit_lock}} & pr.commit_enable));
              pn.alt_function_select = gpx_upd(pr.alt_function_select, wd, allow);
            end
            OFS_DRL: pn.pad.drive_low_select = gpx_upd(pr.pad.drive_low_select, wd, cm);
            OFS_DRM: pn.pad.drive_mid_select = gpx_upd(pr.pad.drive_mid_select, wd, cm);
            OFS_DRH: pn.pad.drive_high_select = gpx_upd(pr.pad.drive_high_select, wd, cm);
            OFS_ODR: pn.pad.open_drain_select = gpx_upd(pr.pad.open_drain_select, wd, cm);
            OFS_PUR: pn.pad.pull_up_select = gpx_upd(pr.pad.pull_up_select, wd, cm);
            OFS_PDR: pn.pad.pull_down_select = gpx_upd(pr.pad.pull_down_select, wd, cm);
            OFS_SLR: pn.pad.slew_limit_select = gpx_upd(pr.pad.slew_limit_select, wd, cm);
            OFS_DEN: begin
              pn.pad.digital_input_enable = gpx_upd(pr.pad.digital_input_enable, wd, cm);
            end
            OFS_LOCK: pn.commit_lock = (req.wdata != UNLOCK_KEY);
            OFS_CR: begin
              // only the protected pins have writable commit bits
              if (!pr.commit_lock) begin
                pn.commit_enable = gpx_upd(pr.commit_enable, wd, cm & dbg);
              end
            end
            default: pn = pr;
          endcase
        end
      end

      // input pins capture the synchronised level, over any data write
      pn.pin_value_reg = gpx_upd(pn.pin_value_reg, inv, ~pr.pin_direction_select & cm);

      // edge and level detection on the filtered input
      rise = inv & ~pr.prev_in;
      fall = ~inv & pr.prev_in;
      edg = (pr.irq_both_edges_select & (rise | fall)) |
            (~pr.irq_both_edges_select & pr.irq_event_polarity & rise) |
            (~pr.irq_both_edges_select & ~pr.irq_event_polarity & fall);
      lvl = ~(inv ^ pr.irq_event_polarity);
      pn.prev_in = inv;
      // edges stick until cleared and a new edge beats the clear;
      // levels follow the pin, so the source must hold them
      pn.irq_raw_status = cm & ((pr.irq_sense_select & lvl) |
                          (~pr.irq_sense_select & ((pr.irq_raw_status & ~clr) | edg)));

      // single port interrupt from masked status
      nxt_st.irq[p] = |(pn.irq_raw_status & pn.irq_mask);

      // pad drive: peripheral or data register, open drain only pulls low
      ov = (pn.alt_function_select & alt_out[p*GPX_W +: GPX_W]) |
           (~pn.alt_function_select & pn.pin_value_reg);
      ev = (pn.alt_function_select & alt_oe[p*GPX_W +: GPX_W]) |
           (~pn.alt_function_select & pn.pin_direction_select);
      nxt_st.pin_out[p*GPX_W +: GPX_W] = ov & ~pn.pad.open_drain_select & cm;
      nxt_st.pin_oe[p*GPX_W +: GPX_W] = ev & (~pn.pad.open_drain_select | ~ov) & cm;

      // register reads, answered on the next edge
      if (req.rd && sel) begin
        rv = '0;
        if (a[11:10] == 2'b00) begin
          rv[7:0] = pr.pin_value_reg & a[9:2] & cm;
        end else if (a >= OFS_ID_BASE) begin
          // identity words are constants; cell words sit in the top four slots
          if (idx >= 4'(ID_CELL_IDX)) begin
            rv[7:0] = CELL_ID[{idx[1:0], 3'b000} +: 8];
          end else begin
            rv[7:0] = PERIPH_ID[{idx[2:0], 3'b000} +: 8];
          end
        end else begin
          case (a)
            OFS_DIR: rv[7:0] = pr.pin_direction_select;
            OFS_IS: rv[7:0] = pr.irq_sense_select;
            OFS_IBE: rv[7:0] = pr.irq_both_edges_select;
            OFS_IEV: rv[7:0] = pr.irq_event_polarity;
            OFS_IM: rv[7:0] = pr.irq_mask;
            OFS_RIS: rv[7:0] = pr.irq_raw_status;
            OFS_MIS: rv[7:0] = pr.irq_raw_status & pr.irq_mask;
            OFS_AFSEL: rv[7:0] = pr.alt_function_select;
            OFS_DRL: rv[7:0] = pr.pad.drive_low_select;
            OFS_DRM: rv[7:0] = pr.pad.drive_mid_select;
            OFS_DRH: rv[7:0] = pr.pad.drive_high_select;
            OFS_ODR: rv[7:0] = pr.pad.open_drain_select;
            OFS_PUR: rv[7:0] = pr.pad.pull_up_select;
            OFS_PDR: rv[7:0] = pr.pad.pull_down_select;
            OFS_SLR: rv[7:0] = pr.pad.slew_limit_select;
            OFS_DEN: rv[7:0] = pr.pad.digital_input_enable;
            OFS_LOCK: rv[0] = pr.commit_lock;
            OFS_CR: rv[7:0] = pr.commit_enable;
            default: rv = '0;
          endcase
          rv[7:0] = rv[7:0] & cm;
        end
        nxt_st.rdata = rv;
        nxt_st.rd_valid = 1'b1;
      end
      nxt_st.prt[p] = pn;
    end
  end

  // every reset reloads the full default image, debug pins included
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign rd_valid = st_ff.rd_valid;
  assign pin_out = st_ff.pin_out;
  assign pin_oe = st_ff.pin_oe;
  assign irq = st_ff.irq;
  // peripherals see the filtered level, not gated by digital_input_enable as the data register is
  assign alt_in = pin_sync;

  // per-port checks
  for (genvar g = 0; g < GPX_PORTS; g++) begin : g_chk
    localparam logic [7:0] CM = PAD_MASK[g*GPX_W +: GPX_W];
    localparam logic [7:0] DB = DBG_PINS[g*GPX_W +: GPX_W];

    a_reset_cfg:
    assert property (@(posedge mclk) disable iff (rst)
      $past(rst) |-> st_ff.prt[g].alt_function_select == DB &&
        st_ff.prt[g].pad.digital_input_enable == DB &&
        st_ff.prt[g].pad.pull_up_select == DB &&
        st_ff.prt[g].pad.pull_down_select == 8'h00 && pin_oe[g*GPX_W +: GPX_W] == 8'h00)
      else $error("port config wrong after reset");

    a_data_mask:
    assert property (@(posedge mclk) disable iff (rst)
      (req.wr && req.port == 3'(g) && req.addr[11:10] == 2'b00) |=>
        ((st_ff.prt[g].pin_value_reg ^ $past(st_ff.prt[g].pin_value_reg)) &
         $past(st_ff.prt[g].pin_direction_select) & ~$past(req.addr[9:2])) == 8'h00)
      else $error("masked data bit changed on write");

    a_read_mask:
    assert property (@(posedge mclk) disable iff (rst)
      (req.rd && req.port == 3'(g) && req.addr[11:10] == 2'b00) |=>
        rd_valid && (rdata[7:0] & ~$past(req.addr[9:2])) == 8'h00 && rdata[31:8] == '0)
      else $error("masked data bit read nonzero");

    a_input_capture:
    assert property (@(posedge mclk) disable iff (rst)
      1'b1 |=> ((st_ff.prt[g].pin_value_reg ^ $past(pin_sync[g*GPX_W +: GPX_W])) &
        ~$past(st_ff.prt[g].pin_direction_select) &
        $past(st_ff.prt[g].pad.digital_input_enable) & CM) == 8'h00)
      else $error("input pin not captured");

    a_irq_merge:
    assert property (@(posedge mclk) disable iff (rst)
      irq[g] == |(st_ff.prt[g].irq_raw_status & st_ff.prt[g].irq_mask))
      else $error("port interrupt not the or of masked status");

    a_edge_latch:
    assert property (@(posedge mclk) disable iff (rst)
      1'b1 |=> ($past(st_ff.prt[g].irq_raw_status & ~st_ff.prt[g].irq_sense_select) &
        ~($past(req.wdata[7:0]) &
          {8{$past(req.wr && req.port == 3'(g) && req.addr == OFS_ICR)}}) &
        ~st_ff.prt[g].irq_raw_status) == 8'h00)
      else $error("latched edge lost without clear");

    a_clear_w1c:
    assert property (@(posedge mclk) disable iff (rst)
      (req.wr && req.port == 3'(g) && req.addr == OFS_ICR &&
       st_ff.prt[g].prev_in ==
         (pin_sync[g*GPX_W +: GPX_W] & st_ff.prt[g].pad.digital_input_enable)) |=>
        (st_ff.prt[g].irq_raw_status &
         $past(req.wdata[7:0] & ~st_ff.prt[g].irq_sense_select)) == 8'h00)
      else $error("clear did not drop latched edge");

    a_commit_guard:
    assert property (@(posedge mclk) disable iff (rst)
      (req.wr && req.port == 3'(g) && st_ff.prt[g].commit_lock) |=>
        ((st_ff.prt[g].alt_function_select ^ $past(st_ff.prt[g].alt_function_select)) &
         DB) == 8'h00)
      else $error("protected alt select changed while locked");

    a_drive_out:
    assert property (@(posedge mclk) disable iff (rst)
      ((st_ff.prt[g].pin_direction_select & ~st_ff.prt[g].alt_function_select &
        ~st_ff.prt[g].pad.open_drain_select & CM) &
       ~(pin_oe[g*GPX_W +: GPX_W] &
         ~(pin_out[g*GPX_W +: GPX_W] ^ st_ff.prt[g].pin_value_reg))) == 8'h00)
      else $error("output pin not driving its data bit");

    a_input_hiz:
    assert property (@(posedge mclk) disable iff (rst)
      (~st_ff.prt[g].pin_direction_select & ~st_ff.prt[g].alt_function_select &
       pin_oe[g*GPX_W +: GPX_W]) == 8'h00)
      else $error("input pin is driven");

    // open drain output: never high, drive enable only while the bit is 0
    a_open_drain:
    assert property (@(posedge mclk) disable iff (rst)
      ((st_ff.prt[g].pin_direction_select & ~st_ff.prt[g].alt_function_select &
        st_ff.prt[g].pad.open_drain_select & CM) &
       (pin_out[g*GPX_W +: GPX_W] |
        ~(pin_oe[g*GPX_W +: GPX_W] ^ st_ff.prt[g].pin_value_reg))) == 8'h00)
      else $error("open drain pin driven wrongly");

    // peripheral owns the pad one edge after it asks; the reset edge is skipped
    // because the reset image does not look at the peripheral inputs
    a_alt_handover:
    assert property (@(posedge mclk) disable iff (rst)
      !$past(rst) |->
        ((st_ff.prt[g].alt_function_select & ~st_ff.prt[g].pad.open_drain_select & CM) &
         ((pin_out[g*GPX_W +: GPX_W] ^ $past(alt_out[g*GPX_W +: GPX_W])) |
          (pin_oe[g*GPX_W +: GPX_W] ^ $past(alt_oe[g*GPX_W +: GPX_W])))) == 8'h00)
      else $error("alternate pin not following its peripheral");

    // level status tracks the filtered pin with no latching
    a_level_follow:
    assert property (@(posedge mclk) disable iff (rst)
      1'b1 |=> ((st_ff.prt[g].irq_raw_status ^
        ~($past(pin_sync[g*GPX_W +: GPX_W] & st_ff.prt[g].pad.digital_input_enable) ^
          $past(st_ff.prt[g].irq_event_polarity))) &
        $past(st_ff.prt[g].irq_sense_select) & CM) == 8'h00)
      else $error("level status not following the pin");
  end
endmodule

// >>> rtl/gpx_pkg.sv
// shared constants, carrier types and reset helpers for the gpio port bank
package gpx_pkg;
  localparam int GPX_PORTS = 8;
  localparam int GPX_W = 8;
  localparam int GPX_PINS = GPX_PORTS * GPX_W;

  // register offsets within one port
  localparam logic [11:0] OFS_DIR = 12'h400;
  localparam logic [11:0] OFS_IS = 12'h404;
  localparam logic [11:0] OFS_IBE = 12'h408;
  localparam logic [11:0] OFS_IEV = 12'h40C;
  localparam logic [11:0] OFS_IM = 12'h410;
  localparam logic [11:0] OFS_RIS = 12'h414;
  localparam logic [11:0] OFS_MIS = 12'h418;
  localparam logic [11:0] OFS_ICR = 12'h41C;
  localparam logic [11:0] OFS_AFSEL = 12'h420;
  localparam logic [11:0] OFS_DRL = 12'h500;
  localparam logic [11:0] OFS_DRM = 12'h504;
  localparam logic [11:0] OFS_DRH = 12'h508;
  localparam logic [11:0] OFS_ODR = 12'h50C;
  localparam logic [11:0] OFS_PUR = 12'h510;
  localparam logic [11:0] OFS_PDR = 12'h514;
  localparam logic [11:0] OFS_SLR = 12'h518;
  localparam logic [11:0] OFS_DEN = 12'h51C;
  localparam logic [11:0] OFS_LOCK = 12'h520;
  localparam logic [11:0] OFS_CR = 12'h524;
  localparam logic [11:0] OFS_ID_BASE = 12'hFD0;
  localparam int ID_CELL_IDX = 12;

  // reset values; debug pins are port 1 bit 7 and port 2 bits 3:0
  localparam logic [GPX_PINS-1:0] DBG_PINS = 64'h0000_0000_000F_8000;
  localparam logic [7:0] RST_DRL = 8'hFF;
  localparam logic RST_LOCK = 1'b1;

  typedef struct packed {
    logic [7:0] pull_up_select;
    logic [7:0] pull_down_select;
    logic [7:0] drive_low_select;
    logic [7:0] drive_mid_select;
    logic [7:0] drive_high_select;
    logic [7:0] slew_limit_select;
    logic [7:0] open_drain_select;
    logic [7:0] digital_input_enable;
  } gpx_pad_s;

  typedef struct packed {
    logic [7:0] pin_value_reg;
    logic [7:0] pin_direction_select;
    logic [7:0] irq_sense_select;
    logic [7:0] irq_both_edges_select;
    logic [7:0] irq_event_polarity;
    logic [7:0] irq_mask;
    logic [7:0] irq_raw_status;
    logic [7:0] alt_function_select;
    logic [7:0] commit_enable;
    logic commit_lock;
    logic [7:0] prev_in;
    gpx_pad_s pad;
  } gpx_port_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] port;
    logic [11:0] addr;
    logic [31:0] wdata;
  } gpx_req_s;

  typedef struct packed {
    gpx_port_s [GPX_PORTS-1:0] prt;
    logic [GPX_PINS-1:0] pin_out;
    logic [GPX_PINS-1:0] pin_oe;
    logic [GPX_PORTS-1:0] irq;
    logic [31:0] rdata;
    logic rd_valid;
  } gpx_top_s;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] q;
  } gpx_sync_s;

  // merge new bits into old where mask is set
  function automatic logic [7:0] gpx_upd(input logic [7:0] o, input logic [7:0] n,
                                         input logic [7:0] m);
    return (o & ~m) | (n & m);
  endfunction

  // reset image of the whole bank
  function automatic gpx_top_s gpx_rst_top();
    gpx_top_s r;
    logic [7:0] d;
    r = '0;
    for (int p = 0; p < GPX_PORTS; p++) begin
      d = DBG_PINS[p*GPX_W +: GPX_W];
      r.prt[p].alt_function_select = d;
      r.prt[p].pad.digital_input_enable = d;
      r.prt[p].pad.pull_up_select = d;
      r.prt[p].pad.drive_low_select = RST_DRL;
      r.prt[p].commit_enable = ~d;
      r.prt[p].commit_lock = RST_LOCK;
    end
    return r;
  endfunction
endpackage

// >>> rtl/gpx_sync.sv
// three-stage pin synchroniser with agreement filter
module gpx_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // raw pins in, filtered level out
  input wire logic [7:0] d,
  output logic [7:0] q
);
  import gpx_pkg::*;

  gpx_sync_s st_ff;
  gpx_sync_s nxt_st;

  // s1 feeds only s2; q moves only when s2 and s3 agree
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.q = (st_ff.q & (st_ff.s2 ^ st_ff.s3)) | (st_ff.s3 & ~(st_ff.s2 ^ st_ff.s3));
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.q;
endmodule

// >>> verif/gpx_pad_model.sv
// pad and pin model for the far side of the gpio bank
module gpx_pad_model (
  // clock
  input wire logic mclk,
  // bank side of the pads
  input wire logic [63:0] pin_out,
  input wire logic [63:0] pin_oe,
  input gpx_pkg::gpx_pad_s [7:0] pad_cfg,
  // outside drivers set by the bench
  input wire logic [63:0] ext_en,
  input wire logic [63:0] ext_val,
  // level the bank sees
  output logic [63:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpx_pkg::*;
  logic [63:0] last_ff = '0;

  // resolve each pad; a floating pad toggles so no lucky value settles
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pad_cfg[i / 8].pull_up_select[i % 8]) pin_in[i] = 1'b1;
      else if (pad_cfg[i / 8].pull_down_select[i % 8]) pin_in[i] = 1'b0;
      else pin_in[i] = ~last_ff[i];
    end
  end

  // history for the floating pads
  always_ff @(posedge mclk) begin
    last_ff <= pin_in;
  end
endmodule

// >>> verif/testbench.sv
// self-checking bench for the gpio bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gpx_pkg::*;
  localparam logic [31:0] KEY = 32'hC0DE_0001; // arbitrary value
  localparam logic [63:0] PID = 64'h8877_6655_4433_2211; // arbitrary value
  localparam logic [31:0] CID = 32'hD4C3_B2A1; // arbitrary value
  localparam logic [63:0] PMASK = 64'h3FFF_FFFF_FFFF_FFFF;
  logic mclk = 1'b0;
  logic rst;
  gpx_req_s req;
  logic [31:0] rdata;
  logic rd_valid;
  logic [63:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in, ext_en, ext_val;
  gpx_pad_s [7:0] pad_cfg;
  logic [7:0] irq, m, ex;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  logic [11:0] ta[4] = '{12'h098, 12'h0C4, 12'h000, 12'h204};
  logic [7:0] td[4] = '{8'hEB, 8'h5A, 8'hFF, 8'h3C};

  gpx_gpio #(.PAD_MASK(PMASK), .UNLOCK_KEY(KEY), .PERIPH_ID(PID), .CELL_ID(CID)) gpx_gpio_i (
    .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rd_valid(rd_valid),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pad_cfg(pad_cfg),
    .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in), .irq(irq));
  gpx_pad_model gpx_pad_model_i (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pad_cfg(pad_cfg), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // one write strobe, released after the taking edge
  task automatic wr(input int p, input logic [11:0] a, input logic [31:0] d);
    tick(1);
    req = {1'b1, 1'b0, p[2:0], a, d};
    tick(1);
    req.wr = 1'b0;
  endtask

  // read strobe; data is valid while rd_valid pulses one edge later
  task automatic rc(input int p, input logic [11:0] a, input logic [31:0] e);
    tick(1);
    req = {1'b0, 1'b1, p[2:0], a, 32'h0};
    tick(1);
    req.rd = 1'b0;
    check((rd_valid === 1'b1) ? rdata : 32'hDEAD_DEAD, e);
  endtask

  task automatic reset_dut();
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
  endtask

  function automatic logic [31:0] rexp(input int p);
    return (p == 1) ? 32'h80 : (p == 2) ? 32'h0F : 32'h0;
  endfunction

  function automatic logic [7:0] pv(input int i);
    return 8'h19 + 8'(i * 32);
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    req = '0;
    ext_en = '0;
    ext_val = '0;
    alt_out = '0;
    alt_oe = '0;
    reset_dut();
    // reset image of every port
    check(pin_oe[63:32] | pin_oe[31:0], 32'h0);
    for (int p = 0; p < 8; p++) begin
      rc(p, 12'h420, rexp(p));
      rc(p, 12'h51C, rexp(p));
      rc(p, 12'h510, rexp(p));
      rc(p, 12'h514, 32'h0);
    end
    rc(1, 12'h524, 32'h7F);
    rc(2, 12'h524, 32'hF0);
    rc(0, 12'h520, 32'h1);
    $display("test reset done");
    // each port keeps its own direction; port 7 lacks pads 7:6
    for (int p = 0; p < 8; p++) wr(p, 12'h400, 32'(8'h11 * p));
    for (int p = 0; p < 7; p++) rc(p, 12'h400, 32'(8'h11 * p));
    rc(7, 12'h400, 32'h37);
    wr(0, 12'h600, 32'hFF);
    rc(0, 12'h600, 32'h0);
    $display("test ports done");
    // mixed direction on port 0
    ext_en[7:0] = 8'h0F;
    ext_val[7:0] = 8'h0C;
    wr(0, 12'h51C, 32'hFF);
    wr(0, 12'h400, 32'hF0);
    wr(0, 12'h3FC, 32'hA5);
    tick(8);
    check({24'h0, pin_oe[7:0]}, 32'hF0);
    check({24'h0, pin_out[7:4], 4'h0}, 32'hA0);
    ext_val[7:0] = 8'h03;
    tick(1);
    check({28'h0, alt_in[3:0]}, 32'hC);
    tick(8);
    check({28'h0, alt_in[3:0]}, 32'h3);
    rc(0, 12'h3FC, 32'hA3);
    $display("test direction done");
    // masked writes and reads through address bits 9:2
    wr(0, 12'h400, 32'hFF);
    wr(0, 12'h3FC, 32'h0);
    ex = 8'h0;
    foreach (ta[i]) begin
      wr(0, ta[i], {24'h0, td[i]});
      m = ta[i][9:2];
      ex = (ex & ~m) | (td[i] & m);
      rc(0, 12'h3FC, {24'h0, ex});
      rc(0, ta[i], {24'h0, ex & m});
    end
    check({24'h0, pin_out[7:0]}, {24'h0, ex});
    // open drain: pin_out held low, enable only on the 0 bits
    wr(0, 12'h50C, 32'hFF);
    check({16'h0, pin_oe[7:0], pin_out[7:0]}, {16'h0, ~ex, 8'h00});
    $display("test masking done");
    // port 3 interrupts: rise, fall, both, high, low on bits 0..4
    ext_en[31:24] = 8'hFF;
    ext_val[31:24] = 8'h00;
    wr(3, 12'h400, 32'h0);
    wr(3, 12'h51C, 32'hFF);
    wr(3, 12'h410, 32'h0);
    wr(3, 12'h404, 32'h18);
    wr(3, 12'h408, 32'h04);
    wr(3, 12'h40C, 32'h09);
    tick(8);
    wr(3, 12'h41C, 32'hFF);
    rc(3, 12'h414, 32'h10);
    wr(3, 12'h410, 32'h01);
    rc(3, 12'h418, 32'h0);
    check({24'h0, irq}, 32'h0);
    ext_val[31:24] = 8'h0F;
    tick(8);
    rc(3, 12'h414, 32'h1D);
    rc(3, 12'h418, 32'h01);
    check({24'h0, irq}, 32'h08);
    ext_val[31:24] = 8'h00;
    tick(8);
    rc(3, 12'h414, 32'h17);
    wr(3, 12'h41C, 32'h0);
    rc(3, 12'h414, 32'h17);
    wr(3, 12'h41C, 32'h01);
    rc(3, 12'h414, 32'h16);
    check({24'h0, irq}, 32'h0);
    wr(3, 12'h410, 32'h1F);
    tick(2);
    check({24'h0, irq}, 32'h08);
    rc(3, 12'h418, 32'h16);
    $display("test interrupts done");
    // port 4 handed to a peripheral and back
    alt_out[39:32] = 8'h5A;
    alt_oe[39:32] = 8'hFF;
    wr(4, 12'h51C, 32'hFF);
    wr(4, 12'h400, 32'h0);
    wr(4, 12'h420, 32'hFF);
    tick(8);
    check({pin_oe[39:32], pin_out[39:32], alt_in[39:32], 8'h0}, 32'hFF5A_5A00);
    wr(4, 12'h420, 32'h0);
    tick(2);
    check({24'h0, pin_oe[39:32]}, 32'h0);
    $display("test alternate done");
    // protected debug pins need unlock and commit
    wr(1, 12'h420, 32'h0);
    rc(1, 12'h420, 32'h80);
    wr(1, 12'h520, KEY);
    rc(1, 12'h520, 32'h0);
    wr(1, 12'h524, 32'hFF);
    wr(1, 12'h420, 32'h0);
    rc(1, 12'h420, 32'h0);
    wr(2, 12'h420, 32'h0);
    rc(2, 12'h420, 32'h0F);
    $display("test commit done");
    // pad settings of port 5
    for (int i = 0; i < 8; i++) wr(5, 12'h500 + 12'(4 * i), {24'h0, pv(i)});
    for (int i = 0; i < 8; i++) rc(5, 12'h500 + 12'(4 * i), {24'h0, pv(i)});
    check(pad_cfg[5][63:32], {pv(4), pv(5), pv(0), pv(1)});
    check(pad_cfg[5][31:0], {pv(2), pv(6), pv(3), pv(7)});
    $display("test pads done");
    // identity words are read only
    wr(0, 12'hFE0, 32'hFF);
    for (int i = 0; i < 4; i++) begin
      rc(0, 12'hFD0 + 12'(4 * i), {24'h0, PID[32 + 8 * i +: 8]});
      rc(0, 12'hFE0 + 12'(4 * i), {24'h0, PID[8 * i +: 8]});
      rc(0, 12'hFF0 + 12'(4 * i), {24'h0, CID[8 * i +: 8]});
    end
    $display("test identity done");
    // second reset mid-run restores defaults
    reset_dut();
    rc(1, 12'h420, 32'h80);
    rc(2, 12'h510, 32'h0F);
    rc(0, 12'h400, 32'h0);
    rc(1, 12'h520, 32'h1);
    check(pin_oe[63:32] | pin_oe[31:0], 32'h0);
    $display("test second reset done");
    finish_test();
  end
endmodule
